// >>> design/mic_pkg.sv
// Purpose: shared constants, types and register map of the interrupt controller
// Assumes: AXI4-Lite register access, one 8-bit register per aligned word
// Notes: vectors, bit positions and codes are named here; some fields use literal bit ranges
// Function
// R1 - second register: flags 6..4, enables 2..0
// R2 - external register: pin flags 7..4, enables 3..0
// R3 - accepted request pushes PC, loads vector
// R4 - return from interrupt pops saved PC
// R5 - servicing clears global enable, no nesting
// R6 - blocked requests still set and hold flags
// R7 - software re-enables global enable for nesting
// R8 - full stack blocks acknowledge until popped
// R9 - running: vector jump 2-3 instructions later
// R10 - after wake-up: jump 3 cycles later; the code waits 3 instruction boundaries
// R11 - requests sampled on sample clock phase
// R12 - fixed priority and vector table
// R13 - external request wins over internal
// R14 - any pin flag set sets grouped flag
// R15 - grouped service clears grouped flag, enable
// R16 - two-bit edge select per pin
// R17 - pin needs enable, edge and input direction
// R18 - vector needs global, own enable, flag
// R19 - conversion done sets flag; service clears
// R20 - counter overflow sets flag; service clears
// R21 - time base overflow sets flag; service clears
// R22 - time base 0 period 2^12..2^15
// R23 - flag rising wakes, enables ignored
// R24 - global enable bit 0 gates every vector
// R25 - return-from-interrupt also sets global enable
// R26 - software clears pin flags after service
// R27 - software writes set or clear flags
package mic_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_FLAGS_0 = 8'h00;
    localparam logic [7:0] OFF_FLAGS_1 = 8'h04;
    localparam logic [7:0] OFF_EXT = 8'h08;
    localparam logic [7:0] OFF_EDGE = 8'h0C;
    localparam logic [7:0] OFF_TMR_CTRL = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    // field positions
    localparam int B_EMI = 0;
    localparam int B_EN_LO = 1;
    localparam int B_FLAG_LO = 4;
    localparam int B1_EN_LO = 0;
    localparam int B_TB0P_LO = 4;
    localparam int B_TOTHER_LO = 6;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_EDGE = 8'h00;
    // edge select codes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // sources in priority order: grouped, t0, t1, adc, tb0, tb1
    localparam int NUM_SRC = 6;
    localparam int NUM_EXT = 4;
    localparam logic [47:0] VEC_TABLE = 48'h18_14_10_0C_08_04;
    // instruction boundaries before the jump
    localparam logic [1:0] RUN_INSTR = 2'h2;
    localparam logic [1:0] WAKE_INSTR = 2'h3;
    localparam int TB0_SHIFT_BASE = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_JUMP = 3'b100
    } mic_state_t;
    // hand-over to the program sequencer
    typedef struct packed {
        logic push_pc;
        logic [7:0] vector;
    } mic_jump_t;
    // single-cycle events from neighbouring blocks
    typedef struct packed {
        logic timer0_ovf;
        logic timer1_ovf;
        logic adc_done;
        logic timebase1_ovf;
    } mic_events_t;
endpackage

// >>> design/mic_interrupt_ctrl.sv
// Purpose: vectored interrupt controller with AXI4-Lite registers
// Assumes: one 20 MHz clock; pins are asynchronous; sequencer drives pulses
// Notes: the stack and PC live in the sequencer; this block only requests
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module mic_interrupt_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [3:0] ext_pin,
    input wire logic [3:0] ext_pin_is_input,
    input wire mic_pkg::mic_events_t hw_events,
    input wire logic fs_tick,
    input wire logic sample_clock_phase,
    input wire logic instr_done,
    input wire logic sleep_mode,
    input wire logic stack_full,
    input wire logic reti_exec,
    input wire logic ret_exec,
    output mic_pkg::mic_jump_t jump,
    output logic pop_pc,
    output logic wakeup,
    output logic timebase0_ovf
);
    import mic_pkg::*;

    // interrupt state
    logic [NUM_SRC-1:0] flag; // grouped, t0, t1, adc, tb0, tb1
    logic [NUM_SRC-1:0] irq_en; // enables in the same order
    logic global_irq_enable;
    logic [NUM_EXT-1:0] ext_flag;
    logic [NUM_EXT-1:0] ext_en;
    logic [7:0] edge_sel; // two bits per pin
    logic [1:0] timebase0_period;
    logic [1:0] tmr_other; // stored for the timer block, unused here
    logic [14:0] tb0_cnt;
    mic_state_t state;
    logic [2:0] win_idx; // latched winner
    logic [1:0] instr_left;
    logic woke; // set by a wake-up, chooses the longer latency
    logic [3:0] pin_s1, pin_s2, pin_d;

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge aclk) begin
        pin_s1 <= ext_pin;
        pin_s2 <= pin_s1;
        pin_d <= pin_s2;
    end

    // bus decode
    wire wr_fire = awvalid && wvalid && !bvalid;
    wire wr_en = wr_fire && wstrb[0];
    wire wr_f0 = wr_en && (awaddr == OFF_FLAGS_0);
    wire wr_f1 = wr_en && (awaddr == OFF_FLAGS_1);
    wire wr_ext = wr_en && (awaddr == OFF_EXT);
    wire wr_edge = wr_en && (awaddr == OFF_EDGE);
    wire wr_tmr = wr_en && (awaddr == OFF_TMR_CTRL);
    wire wr_known = (awaddr == OFF_FLAGS_0) || (awaddr == OFF_FLAGS_1) ||
        (awaddr == OFF_EXT) || (awaddr == OFF_EDGE) ||
        (awaddr == OFF_TMR_CTRL) || (awaddr == OFF_STATUS);
    wire rd_fire = arvalid && !rvalid;
    wire [7:0] wb = wdata[7:0];
    assign awready = wr_fire;
    assign wready = wr_fire;
    assign arready = !rvalid;

    // edge detection per pin
    wire [3:0] pin_rise = pin_s2 & ~pin_d;
    wire [3:0] pin_fall = ~pin_s2 & pin_d;
    logic [3:0] ext_set;
    always_comb begin
        for (int i = 0; i < NUM_EXT; i++) begin
            case (edge_sel[2*i +: 2]) // R16
                EDGE_RISE: ext_set[i] = pin_rise[i];
                EDGE_FALL: ext_set[i] = pin_fall[i];
                EDGE_BOTH: ext_set[i] = pin_rise[i] | pin_fall[i];
                default: ext_set[i] = 1'b0;
            endcase
            // pin counts only when enabled and configured as input
            ext_set[i] = ext_set[i] && ext_en[i] && ext_pin_is_input[i]; // R17
        end
    end

    // time base 0 divider on the fs enable pulse
    wire [4:0] tb0_shift = 5'(TB0_SHIFT_BASE) + {3'h0, timebase0_period}; // R22
    wire [15:0] tb0_span = 16'h0001 << tb0_shift;
    wire [14:0] tb0_last = 15'(tb0_span - 16'h0001);
    wire tb0_wrap = fs_tick && (tb0_cnt >= tb0_last);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tb0_cnt <= 15'h0000;
            timebase0_ovf <= 1'b0;
        end else begin
            // >= keeps a shorter period after a code change from overshooting
            tb0_cnt <= tb0_wrap ? 15'h0000 : (fs_tick ? tb0_cnt + 15'h0001 : tb0_cnt);
            timebase0_ovf <= tb0_wrap; // R22
        end
    end

    // service decision
    wire jump_now = (state == ST_JUMP);
    wire [NUM_SRC-1:0] svc_clr = jump_now ? NUM_SRC'(1) << win_idx : '0;
    // external flags: hardware set beats a software clear
    wire [3:0] next_ext_flag = ext_set | (wr_ext ? wb[7:4] : ext_flag); // R27
    wire mff_set = |(next_ext_flag & ~ext_flag); // R14
    wire [NUM_SRC-1:0] hw_set = {timebase0_ovf, hw_events.timebase1_ovf,
        hw_events.adc_done, hw_events.timer1_ovf, hw_events.timer0_ovf, mff_set};
    // order above is tb0 first only for readability; reorder to source index
    wire [NUM_SRC-1:0] src_set = {hw_set[4], hw_set[5], hw_set[3:0]}; // R19 R20 R21
    wire [NUM_SRC-1:0] sw_we = {{3{wr_f1}}, {3{wr_f0}}};
    wire [NUM_SRC-1:0] sw_val = {wb[6:4], wb[6:4]};
    wire [NUM_SRC-1:0] sw_flag = {sw_val[5:3], sw_val[2:0]};
    logic [NUM_SRC-1:0] next_flag;
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            // set wins over both service clear and software clear
            if (src_set[i]) begin
                next_flag[i] = 1'b1; // R6
            end else if (sw_we[i]) begin
                next_flag[i] = sw_flag[i]; // R27
            end else if (svc_clr[i]) begin
                next_flag[i] = 1'b0; // R15 R19 R20 R21
            end else begin
                next_flag[i] = flag[i];
            end
        end
    end

    // wake-up ignores enables: only a fresh low-to-high flag counts
    wire any_rise = |(next_flag & ~flag) || |(next_ext_flag & ~ext_flag); // R23

    // pending and priority: lowest index wins, grouped external first
    wire [NUM_SRC-1:0] pend = flag & irq_en & {NUM_SRC{global_irq_enable}}; // R18 R24
    logic [2:0] prio_idx;
    always_comb begin
        prio_idx = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                prio_idx = 3'(i); // R12 R13
            end
        end
    end
    wire accept = (state == ST_IDLE) && sample_clock_phase && (|pend) &&
        !stack_full && !sleep_mode; // R8 R11

    // register update
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag <= '0;
            irq_en <= '0;
            global_irq_enable <= 1'b0;
            ext_flag <= '0;
            ext_en <= '0;
            edge_sel <= RST_EDGE;
            timebase0_period <= 2'h0;
            tmr_other <= 2'h0;
        end else begin
            flag <= next_flag;
            ext_flag <= next_ext_flag; // R2
            if (wr_f0) begin
                irq_en[2:0] <= wb[B_EN_LO +: 3];
            end
            if (wr_f1) begin
                irq_en[5:3] <= wb[B1_EN_LO +: 3]; // R1
            end
            if (wr_ext) begin
                ext_en <= wb[3:0]; // R2
            end
            if (wr_edge) begin
                edge_sel <= wb; // R16
            end
            if (wr_tmr) begin
                timebase0_period <= wb[B_TB0P_LO +: 2];
                tmr_other <= wb[B_TOTHER_LO +: 2];
            end
            // return-from-interrupt re-enables, service disables, then software
            if (reti_exec) begin
                global_irq_enable <= 1'b1; // R25
            end else if (jump_now) begin
                global_irq_enable <= 1'b0; // R5 R15
            end else if (wr_f0) begin
                global_irq_enable <= wb[B_EMI]; // R7 R24
            end
        end
    end

    // sequencer hand-shake state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            win_idx <= 3'h0;
            instr_left <= 2'h0;
            woke <= 1'b0;
            jump <= '0;
            pop_pc <= 1'b0;
            wakeup <= 1'b0;
        end else begin
            jump.push_pc <= 1'b0;
            pop_pc <= ret_exec || reti_exec; // R4
            wakeup <= sleep_mode && any_rise; // R23
            if (sleep_mode && any_rise) begin
                woke <= 1'b1;
            end
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        win_idx <= prio_idx;
                        instr_left <= woke ? WAKE_INSTR : RUN_INSTR; // R9 R10
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (instr_done) begin
                        instr_left <= instr_left - 2'h1;
                        if (instr_left == 2'h1) begin
                            state <= ST_JUMP;
                        end
                    end
                end
                ST_JUMP: begin
                    // sequencer pushes the PC and loads the vector
                    jump.push_pc <= 1'b1; // R3
                    jump.vector <= VEC_TABLE[{win_idx, 3'h0} +: 8]; // R12
                    woke <= 1'b0;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // read data assembly; unused bits read zero
    wire [7:0] rd_f0 = {1'b0, flag[2:0], irq_en[2:0], global_irq_enable};
    wire [7:0] rd_f1 = {1'b0, flag[5:3], 1'b0, irq_en[5:3]}; // R1
    wire [7:0] rd_tmr = {tmr_other, timebase0_period, 4'h0};
    wire [7:0] rd_stat = {stack_full, woke, win_idx, state};
    logic [7:0] rd_byte;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (araddr)
            OFF_FLAGS_0: rd_byte = rd_f0;
            OFF_FLAGS_1: rd_byte = rd_f1;
            OFF_EXT: rd_byte = {ext_flag, ext_en};
            OFF_EDGE: rd_byte = edge_sel;
            OFF_TMR_CTRL: rd_byte = rd_tmr;
            OFF_STATUS: rd_byte = rd_stat;
            default: begin
                rd_byte = RST_REG;
                rd_ok = 1'b0;
            end
        endcase
    end

    // bus responses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else begin
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            if (rd_fire) begin
                rvalid <= 1'b1;
                rdata <= {24'h00_0000, rd_byte};
                rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_accept;
        accept ##1 (state == ST_WAIT);
    endsequence
    property p_latency;
        s_accept |-> ##[1:1000] (state == ST_JUMP);
    endproperty
    a_latency: assert property (p_latency) else $error("no jump after accept"); // R9
    property p_emi_clear;
        (jump_now && !reti_exec) |=> !global_irq_enable;
    endproperty
    a_emi_clear: assert property (p_emi_clear) else $error("enable kept"); // R5
    property p_reti;
        reti_exec |=> global_irq_enable && pop_pc;
    endproperty
    a_reti: assert property (p_reti) else $error("return misbehaved"); // R25
    property p_full;
        (state == ST_IDLE && stack_full) |=> (state == ST_IDLE);
    endproperty
    a_full: assert property (p_full) else $error("accepted on full stack"); // R8
    property p_gate;
        (state == ST_IDLE && !global_irq_enable) |=> (state == ST_IDLE);
    endproperty
    a_gate: assert property (p_gate) else $error("accepted while disabled"); // R24
    property p_vector;
        jump_now |=> jump.push_pc && jump.vector == VEC_TABLE[{win_idx, 3'h0} +: 8];
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector"); // R12
    property p_prio;
        (accept && pend[0]) |=> (win_idx == 3'h0);
    endproperty
    a_prio: assert property (p_prio) else $error("external not first"); // R13
    property p_group;
        mff_set |=> flag[0];
    endproperty
    a_group: assert property (p_group) else $error("grouped flag missed"); // R14
    property p_wake;
        (sleep_mode && any_rise) |=> wakeup;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up missed"); // R23
    property p_held;
        (src_set != '0) |=> ((flag & $past(src_set)) == $past(src_set));
    endproperty
    a_held: assert property (p_held) else $error("request flag lost"); // R6
    // every executed return must pop the stack
    property p_pop;
        (ret_exec || reti_exec) |=> pop_pc;
    endproperty
    a_pop: assert property (p_pop) else $error("no pop"); // R4
    // acceptance only on the sampling phase
    property p_phase;
        (state == ST_IDLE && !sample_clock_phase) |=> (state == ST_IDLE);
    endproperty
    a_phase: assert property (p_phase) else $error("off-phase accept"); // R11
    // a wake-up selects the longer delay
    property p_wake_len;
        (accept && woke) |=> (instr_left == WAKE_INSTR);
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("short wake delay"); // R10
    // no acceptance while still asleep
    property p_sleep;
        (state == ST_IDLE && sleep_mode) |=> (state == ST_IDLE);
    endproperty
    a_sleep: assert property (p_sleep) else $error("accepted asleep"); // R10
    // service clears the winner unless set again
    property p_svc;
        (jump_now && !src_set[win_idx] && !sw_we[win_idx]) |=> !flag[win_idx];
    endproperty
    a_svc: assert property (p_svc) else $error("flag kept"); // R15
    // the divider overflow is a single pulse
    property p_tb0;
        timebase0_ovf |=> !timebase0_ovf;
    endproperty
    a_tb0: assert property (p_tb0) else $error("tb0 pulse long"); // R22
endmodule

// >>> verif/mic_seq_model.sv
// Purpose: behavioural program sequencer and stack facing the controller
// Assumes: one clock; returns are asked for by the bench as one-cycle pulses
// Notes: a slow setting stretches every instruction to stress the jump delay
`timescale 1ns/1ps
module mic_seq_model #(
    parameter int STACK_DEPTH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire mic_pkg::mic_jump_t jump,
    input wire logic pop_pc,
    input wire logic ret_req,
    input wire logic reti_req,
    output logic instr_done,
    output logic sample_clock_phase,
    output logic stack_full,
    output logic reti_exec,
    output logic ret_exec
);
    import mic_pkg::*;
    int phase; // cycle within the current instruction
    int depth; // return addresses held on the stack
    logic [1:0] pend; // returns waiting for the next boundary
    // one boundary and one sample instant in every instruction
    assign instr_done = aresetn && (phase >= (slow ? 5 : 2));
    assign sample_clock_phase = aresetn && (phase == 1);
    assign stack_full = (depth >= STACK_DEPTH);
    // instruction timing, return execution and stack depth
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 0;
            depth <= 0;
            pend <= 2'h0;
            reti_exec <= 1'b0;
            ret_exec <= 1'b0;
        end else begin
            phase <= instr_done ? 0 : phase + 1;
            // a return is only executed as a whole instruction
            reti_exec <= instr_done & pend[1];
            ret_exec <= instr_done & pend[0];
            pend <= (instr_done ? 2'h0 : pend) | {reti_req, ret_req};
            depth <= depth + int'(jump.push_pc) - int'(pop_pc);
        end
    end
endmodule

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: sequencer model supplies instruction timing and the stack
// Notes: expected flags are tracked by the bench, never copied from reads
`timescale 1ns/1ps
module tb_top;
    import mic_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
    logic awready, wready, bvalid, arready, rvalid, fs_tick, sleep_mode;
    logic [7:0] awaddr, araddr, d, fl0, fl1, last_vec;
    logic [31:0] wdata, rdata, q;
    logic [3:0] wstrb, ext_pin, ext_pin_is_input;
    logic [1:0] bresp, rresp, r;
    mic_events_t hw_events;
    mic_jump_t jump;
    logic sample_clock_phase, instr_done, stack_full, reti_exec, ret_exec;
    logic pop_pc, wakeup, timebase0_ovf, ret_req, reti_req;
    int num_errors, num_checks, cyc, n_wake, n_jump, n_instr, n_pop, n_tb0;
    int tb0_at, tb0_gap, n, p, t0, i0;
    mic_interrupt_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_pin(ext_pin),
        .ext_pin_is_input(ext_pin_is_input), .hw_events(hw_events), .fs_tick(fs_tick),
        .sample_clock_phase(sample_clock_phase), .instr_done(instr_done),
        .sleep_mode(sleep_mode), .stack_full(stack_full), .reti_exec(reti_exec),
        .ret_exec(ret_exec), .jump(jump), .pop_pc(pop_pc), .wakeup(wakeup),
        .timebase0_ovf(timebase0_ovf));
    mic_seq_model seq_u (.aclk(aclk), .aresetn(aresetn), .slow(slow), .jump(jump),
        .pop_pc(pop_pc), .ret_req(ret_req), .reti_req(reti_req), .instr_done(instr_done),
        .sample_clock_phase(sample_clock_phase), .stack_full(stack_full),
        .reti_exec(reti_exec), .ret_exec(ret_exec));
    // 20 MHz clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // event counters and the run limit
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        n_wake <= n_wake + int'(wakeup === 1'b1);
        n_instr <= n_instr + int'(instr_done === 1'b1);
        n_pop <= n_pop + int'(pop_pc === 1'b1);
        if (jump.push_pc === 1'b1) begin
            n_jump <= n_jump + 1;
            last_vec <= jump.vector;
        end
        if (timebase0_ovf === 1'b1) begin
            n_tb0 <= n_tb0 + 1;
            tb0_gap <= cyc - tb0_at;
            tb0_at <= cyc;
        end
        if (cyc == 60000) begin
            num_errors = num_errors + 1;
            final_report();
        end
    end
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one write: address and data together, response taken with bready high
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        q = rdata;
        r = rresp;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        check("register", q, {24'h0, e});
    endtask
    // waits for the next vector jump, counting boundaries since i0
    task automatic wait_jump(input logic [7:0] ev, input int lo, input int hi);
        int j0, k;
        j0 = n_jump;
        k = 0;
        while (n_jump == j0 && k < 300) begin
            @(posedge aclk);
            k++;
        end
        check("jump seen", 32'(n_jump - j0), 32'h1);
        check("vector", {24'h0, last_vec}, {24'h0, ev});
        n = n_instr - i0;
        check("jump delay", 32'(n >= lo && n <= hi), 32'h1);
    endtask
    task automatic do_ret(input logic iret);
        int p0, k;
        p0 = n_pop;
        k = 0;
        reti_req <= iret;
        ret_req <= ~iret;
        @(posedge aclk);
        reti_req <= 1'b0;
        ret_req <= 1'b0;
        while (n_pop == p0 && k < 60) begin
            @(posedge aclk);
            k++;
        end
        check("pop seen", 32'(n_pop - p0), 32'h1);
    endtask
    // pin register image after one edge of a given trigger code
    function automatic logic [7:0] ext_exp(int pin, int code, int dir, int e);
        logic hit;
        hit = (dir != 0) && (((code >> e) & 1) != 0);
        return 8'(1 << pin) | 8'(8'(hit) << (4 + pin));
    endfunction
    initial begin
        {aresetn, awvalid, wvalid, arvalid, slow, fs_tick, sleep_mode} = '0;
        {ret_req, reti_req, ext_pin, ext_pin_is_input, hw_events} = '0;
        {awaddr, araddr, wdata} = '0;
        {bready, rready, wstrb} = 6'h3F;
        void'($urandom(4952));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) rd_chk(8'(4 * i), 8'h00);
        rd(8'h18);
        check("unmapped read", {30'h0, r}, {30'h0, RESP_SLVERR});
        wr(OFF_FLAGS_1, 8'hFF);
        rd_chk(OFF_FLAGS_1, 8'h77);
        wr(OFF_FLAGS_1, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            wr(OFF_EXT, d);
            rd_chk(OFF_EXT, d);
            rd_chk(OFF_FLAGS_0, {3'h0, |d[7:4], 4'h0});
            wr(OFF_EXT, 8'h00);
            wr(OFF_FLAGS_0, 8'h00);
        end
        // every trigger code on a random pin, as output and as input
        for (int i = 0; i < 8; i++) begin
            p = int'($urandom % 4);
            wr(OFF_EDGE, 8'((i % 4) << (2 * p)));
            wr(OFF_EXT, 8'(1 << p));
            ext_pin_is_input <= 4'((i / 4) << p);
            for (int e = 0; e < 2; e++) begin
                ext_pin[p] <= ~ext_pin[p];
                repeat (6) @(posedge aclk);
                rd_chk(OFF_EXT, ext_exp(p, i % 4, i / 4, e));
                wr(OFF_EXT, 8'(1 << p));
            end
        end
        wr(OFF_FLAGS_0, 8'h00);
        // all six sources pending while masked, then served one by one
        fl0 = 8'h7E;
        fl1 = 8'h77;
        wr(OFF_FLAGS_0, fl0);
        wr(OFF_FLAGS_1, fl1);
        n = n_jump;
        repeat (30) @(posedge aclk);
        check("masked jumps", 32'(n_jump - n), 32'h0);
        rd_chk(OFF_FLAGS_0, fl0);
        for (int k = 0; k < 6; k++) begin
            i0 = n_instr;
            if (k == 0) wr(OFF_FLAGS_0, fl0 | 8'h01);
            else do_ret(1'b1);
            wait_jump(8'(4 * k + 4), 2, k == 0 ? 4 : 8);
            if (k < 3) fl0[4 + k] = 1'b0;
            else fl1[1 + k] = 1'b0;
            rd_chk(OFF_FLAGS_0, fl0);
            rd_chk(OFF_FLAGS_1, fl1);
        end
        do_ret(1'b1);
        check("stack depth", 32'(seq_u.depth), 32'h0);
        rd_chk(OFF_FLAGS_0, fl0 | 8'h01);
        // nesting until the stack is full, slow instructions
        slow <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            i0 = n_instr;
            wr(OFF_FLAGS_1, 8'h11);
            wr(OFF_FLAGS_0, 8'h0F);
            if (k < 2) wait_jump(8'h10, 0, 9);
        end
        n = n_jump;
        repeat (40) @(posedge aclk);
        check("full stack jumps", 32'(n_jump - n), 32'h0);
        do_ret(1'b0);
        wait_jump(8'h10, 0, 20);
        do_ret(1'b0);
        rd_chk(OFF_FLAGS_0, 8'h0E);
        do_ret(1'b0);
        check("stack depth", 32'(seq_u.depth), 32'h0);
        slow <= 1'b0;
        // wake-up from each hardware event, only on a rising flag
        wr(OFF_FLAGS_0, 8'h00);
        wr(OFF_FLAGS_1, 8'h00);
        sleep_mode <= 1'b1;
        for (int b = 3; b >= 0; b--) begin
            for (int rep = 0; rep < 2; rep++) begin
                n = n_wake;
                hw_events <= mic_events_t'(4'(1 << b));
                @(posedge aclk);
                hw_events <= '0;
                repeat (5) @(posedge aclk);
                check("wake pulses", 32'(n_wake - n), 32'(rep == 0));
            end
        end
        rd_chk(OFF_FLAGS_0, 8'h60);
        rd_chk(OFF_FLAGS_1, 8'h50);
        sleep_mode <= 1'b0;
        i0 = n_instr;
        wr(OFF_FLAGS_0, 8'h6D);
        wait_jump(8'h08, 3, 5);
        wr(OFF_FLAGS_0, 8'h00);
        wr(OFF_FLAGS_1, 8'h00);
        // time base 0 divider for the two shortest periods
        fs_tick <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            wr(OFF_TMR_CTRL, 8'(c << 4));
            n = n_tb0;
            t0 = 0;
            while (n_tb0 < n + 3 && t0 < 30000) begin
                @(posedge aclk);
                t0++;
            end
            check("tb0 period", 32'(tb0_gap), 32'(4096 << c));
        end
        fs_tick <= 1'b0;
        rd_chk(OFF_FLAGS_1, 8'h20);
        final_report();
    end
endmodule
